// File: pcc_pkg.sv
// Package of offsets, fields, reset values and timing counts for the PLL clock control block
package pcc_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OUTSEL_OFS = 8'h04;
  localparam logic [7:0] PINCFG_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h18;

  // Control field positions
  localparam int CTRL_RST_BIT = 0;
  localparam int CTRL_DETECTOR_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_HIBW_BIT = 5;
  localparam int CTRL_VAR_LSB = 6;
  localparam int CTRL_IDX_LSB = 8;
  localparam int CTRL_DED_BIT = 11;
  localparam logic [11:0] CTRL_RESET = 12'h802;

  // Pin configuration field positions
  localparam int PIN_DIFF_LSB = 0;
  localparam int PIN_INV_LSB = 3;
  localparam int PIN_GPEN_LSB = 8;
  localparam int PIN_GPOUT_LSB = 16;

  // Interrupt event bits
  localparam int EV_LOCK = 0;
  localparam int EV_LOSS = 1;
  localparam int EV_CFG = 2;

  // Output source codes: 0..9 output counters, this one the multiply counter
  localparam logic [3:0] SRC_MULT = 4'hf;
  localparam int NUM_CNT_MAX = 10;
  localparam int NUM_CNT_SMALL = 7;

  // Oscillator control word
  localparam logic [7:0] OSC_NOMINAL = 8'h80;

  // Timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ZERO_DELAY_NS = 8;
  localparam int ZERO_DELAY_CYC = (ZERO_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_EDGES = 16;
  localparam int LOSS_CYC = 64;
  localparam int DRIFT_CYC = 1024;

  // Device variant and location
  typedef enum logic [1:0]
  {
    VAR_FIRST = 2'b00,
    VAR_SECOND_TB = 2'b01,
    VAR_SECOND_LR = 2'b10
  } pcc_variant_e;

  // Clock feedback modes
  typedef enum logic [2:0]
  {
    MODE_SRC_SYNC = 3'b000,
    MODE_NO_COMP = 3'b001,
    MODE_NORMAL = 3'b010,
    MODE_ZERO_DELAY = 3'b011,
    MODE_EXT_FB = 3'b100,
    MODE_LVDS = 3'b101
  } pcc_mode_e;

  // Lock tracking states
  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_LOCKED = 2'b10
  } pcc_state_e;

endpackage

// File: pcc_divider.sv
// Post-scale counter model: a fixed even divider stopped and cleared by reset
`timescale 1ns/1ps
`default_nettype none
module pcc_divider #(
  parameter int HALF = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic clk_q
);

  // Half-period count
  logic [9:0] cnt_q;

  // Toggle every HALF cycles while running; held low otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 10'h000;
      clk_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= 10'h000;
      clk_q <= 1'b0;
    end
    else if (cnt_q == 10'(HALF - 1))
    begin
      cnt_q <= 10'h000;
      clk_q <= ~clk_q;
    end
    else
    begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

endmodule
`default_nettype wire

// File: pcc_top.sv
// PLL clock pin routing, control signals and lock status with an APB register port
`timescale 1ns/1ps
`default_nettype none
module pcc_top #(
  parameter int LOCK_EDGES = pcc_pkg::LOCK_EDGES,
  parameter int LOSS_CYC = pcc_pkg::LOSS_CYC,
  parameter int DRIFT_CYC = pcc_pkg::DRIFT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clk_in,
  input wire logic areset_in,
  input wire logic phase_detector_en_in,
  input wire logic [5:0] pin_i,
  output logic [5:0] pin_o,
  output logic [5:0] pin_oe,
  output logic pll_locked,
  output logic pll_in_reset,
  output logic irq
);

  localparam int NUM_CNTS = pcc_pkg::NUM_CNT_MAX;
  // Software state
  logic [11:0] ctrl_q;
  logic [3:0] outsel_q;
  logic [21:0] pincfg_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_en_q;
  // Synchronisers for pins
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic ref_prev_q;
  logic fb_prev_q;
  // Lock tracking
  pcc_pkg::pcc_state_e state_q;
  logic [7:0] edge_cnt_q;
  logic [9:0] loss_cnt_q;
  logic [10:0] drift_cnt_q;
  logic [7:0] osc_ctrl_q;
  logic [1:0] comp_wait_q;
  // Derived
  logic wr_en;
  logic rd_en;
  logic reset_req;
  logic detector_on;
  logic ref_rise;
  logic fb_rise;
  logic mode_ok;
  logic sel_err;
  logic bw_eff;
  logic compensated;
  logic ext_fb_pin;
  logic src_clk;
  logic ev_lock;
  logic ev_loss;
  logic [2:0] events;
  logic [NUM_CNTS:0] cnt_clk;
  logic [31:0] rd_data;
  logic [5:0] pin_od;
  logic [5:0] pin_oed;
  logic addr_ok;

  pcc_pkg::pcc_variant_e variant;
  pcc_pkg::pcc_mode_e mode;
  logic [2:0] pll_idx;

  assign variant = pcc_pkg::pcc_variant_e'(ctrl_q[pcc_pkg::CTRL_VAR_LSB +: 2]);
  assign mode = pcc_pkg::pcc_mode_e'(ctrl_q[pcc_pkg::CTRL_MODE_LSB +: 3]);
  assign pll_idx = ctrl_q[pcc_pkg::CTRL_IDX_LSB +: 3];

  // APB strobes: one wait state, pready comes from a flop
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && !pready;

  // ********************************************************
  // Pin synchronisers
  // ********************************************************

  // Two flops on every outside level before any logic looks at it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      ref_prev_q <= 1'b0;
      fb_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {phase_detector_en_in, areset_in, ref_clk_in};
      sync2_q <= sync1_q;
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      ref_prev_q <= sync2_q[0];
      fb_prev_q <= ext_fb_pin;
    end
  end

  // Reset from pin or software; detector enabled only if both agree
  assign reset_req = sync2_q[1] || ctrl_q[pcc_pkg::CTRL_RST_BIT];
  assign detector_on = sync2_q[2] && ctrl_q[pcc_pkg::CTRL_DETECTOR_BIT];
  assign ref_rise = sync2_q[0] && !ref_prev_q;
  // Feedback input pin: pair two on top/bottom, pin one on left/right
  assign ext_fb_pin = (variant == pcc_pkg::VAR_SECOND_LR) ? pin_s2_q[1] : pin_s2_q[2];
  assign fb_rise = ext_fb_pin && !fb_prev_q;

  // ********************************************************
  // Mode availability
  // ********************************************************

  // Check mode against variant, location and PLL number
  always_comb
  begin
    mode_ok = 1'b1;
    case (mode)
      pcc_pkg::MODE_EXT_FB:
        mode_ok = (variant != pcc_pkg::VAR_FIRST);
      pcc_pkg::MODE_LVDS:
      begin
        if (variant == pcc_pkg::VAR_SECOND_TB)
          mode_ok = 1'b0;
        else if (variant == pcc_pkg::VAR_FIRST)
          mode_ok = (pll_idx == 3'h2) || (pll_idx == 3'h3) ||
                    (pll_idx == 3'h5) || (pll_idx == 3'h6);
      end
      pcc_pkg::MODE_SRC_SYNC,
      pcc_pkg::MODE_NO_COMP,
      pcc_pkg::MODE_NORMAL,
      pcc_pkg::MODE_ZERO_DELAY:
        mode_ok = 1'b1;
      default:
        mode_ok = 1'b0;
    endcase
    // Single-ended left/right pins leave only external feedback
    if (variant == pcc_pkg::VAR_SECOND_LR && !pincfg_q[pcc_pkg::PIN_DIFF_LSB] &&
        mode != pcc_pkg::MODE_EXT_FB)
      mode_ok = 1'b0;
    // Unknown variant code is never valid
    if (variant == pcc_pkg::pcc_variant_e'(2'b11))
      mode_ok = 1'b0;
  end

  // High bandwidth is dropped in external feedback mode
  assign bw_eff = ctrl_q[pcc_pkg::CTRL_HIBW_BIT] && (mode != pcc_pkg::MODE_EXT_FB);

  // Full compensation only from the dedicated input pins
  assign compensated = pll_locked && mode_ok && ctrl_q[pcc_pkg::CTRL_DED_BIT] &&
                       (mode != pcc_pkg::MODE_NO_COMP);

  // ********************************************************
  // Lock state machine
  // ********************************************************

  // Count reference edges to lock; lose lock when the reference stops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= pcc_pkg::ST_RESET;
      edge_cnt_q <= 8'h00;
      loss_cnt_q <= 10'h000;
      comp_wait_q <= 2'h0;
    end
    else if (reset_req)
    begin
      // Everything cleared while reset is held
      state_q <= pcc_pkg::ST_RESET;
      edge_cnt_q <= 8'h00;
      loss_cnt_q <= 10'h000;
      comp_wait_q <= 2'h0;
    end
    else
    begin
      // Watchdog on the reference clock
      if (ref_rise)
        loss_cnt_q <= 10'h000;
      else if (loss_cnt_q != 10'(LOSS_CYC))
        loss_cnt_q <= loss_cnt_q + 10'h001;
      case (state_q)
        pcc_pkg::ST_RESET:
        begin
          // Released: start resynchronising to the reference
          state_q <= pcc_pkg::ST_ACQUIRE;
          edge_cnt_q <= 8'h00;
        end
        pcc_pkg::ST_ACQUIRE:
        begin
          // Gated detector cannot acquire; external feedback needs the fb pin high at the ref edge too
          if (detector_on && mode_ok && ref_rise &&
              (mode != pcc_pkg::MODE_EXT_FB || fb_rise || ext_fb_pin))
            edge_cnt_q <= edge_cnt_q + 8'h01;
          if (edge_cnt_q == 8'(LOCK_EDGES))
          begin
            // Zero delay mode waits out its fixed compensation delay
            if (mode != pcc_pkg::MODE_ZERO_DELAY ||
                comp_wait_q == 2'(pcc_pkg::ZERO_DELAY_CYC))
              state_q <= pcc_pkg::ST_LOCKED;
            else
              comp_wait_q <= comp_wait_q + 2'h1;
          end
        end
        pcc_pkg::ST_LOCKED:
        begin
          // Reference gone or config invalid drops lock
          if (loss_cnt_q == 10'(LOSS_CYC) || !mode_ok)
          begin
            state_q <= pcc_pkg::ST_ACQUIRE;
            edge_cnt_q <= 8'h00;
            comp_wait_q <= 2'h0;
          end
        end
        default:
          state_q <= pcc_pkg::ST_RESET;
      endcase
    end
  end

  // ********************************************************
  // Oscillator control word
  // ********************************************************

  // Nominal in reset; with detector gated the last value holds and drifts down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_ctrl_q <= pcc_pkg::OSC_NOMINAL;
      drift_cnt_q <= 11'h000;
    end
    else if (reset_req)
    begin
      osc_ctrl_q <= pcc_pkg::OSC_NOMINAL;
      drift_cnt_q <= 11'h000;
    end
    else if (!detector_on)
    begin
      // Slow drift only: one step per long interval
      if (drift_cnt_q == 11'(DRIFT_CYC - 1))
      begin
        drift_cnt_q <= 11'h000;
        if (osc_ctrl_q != 8'h00)
          osc_ctrl_q <= osc_ctrl_q - 8'h01;
      end
      else
      begin
        drift_cnt_q <= drift_cnt_q + 11'h001;
      end
    end
    else
    begin
      // Acquiring: walk the word while edges are counted
      drift_cnt_q <= 11'h000;
      if (state_q == pcc_pkg::ST_ACQUIRE && ref_rise)
        osc_ctrl_q <= osc_ctrl_q + 8'h01;
    end
  end

  // ********************************************************
  // Output counters and source select
  // ********************************************************

  // Post-scale counters plus the multiply counter at the top index
  for (genvar k = 0; k <= NUM_CNTS; k++)
  begin : g_cnt
    pcc_divider #(
      .HALF(k + 1)
    ) u_div (
      .clk(pclk),
      .rst_n(presetn),
      .run(!reset_req && state_q != pcc_pkg::ST_RESET),
      .clk_q(cnt_clk[k])
    );
  end

  // Source range depends on variant and location
  always_comb
  begin
    sel_err = 1'b0;
    src_clk = 1'b0;
    if (outsel_q == pcc_pkg::SRC_MULT)
      src_clk = cnt_clk[NUM_CNTS];
    else if (variant == pcc_pkg::VAR_SECOND_TB && outsel_q < 4'(pcc_pkg::NUM_CNT_MAX))
      src_clk = cnt_clk[outsel_q];
    else if (outsel_q < 4'(pcc_pkg::NUM_CNT_SMALL))
      src_clk = cnt_clk[outsel_q];
    else
      sel_err = 1'b1;
  end

  // ********************************************************
  // Clock pin routing
  // ********************************************************

  // Per pin: clock, inverted clock, user output or input
  always_comb
  begin
    pin_od = 6'h00;
    pin_oed = 6'h00;
    for (int p = 0; p < 3; p++)
    begin
      // Clock on p pin; n pin in phase, or inverted in single-ended use
      pin_od[2 * p] = src_clk;
      pin_od[2 * p + 1] = src_clk ^ (pincfg_q[pcc_pkg::PIN_INV_LSB + p] &&
                                     !pincfg_q[pcc_pkg::PIN_DIFF_LSB + p]);
      pin_oed[2 * p] = 1'b1;
      pin_oed[2 * p + 1] = 1'b1;
    end
    case (variant)
      pcc_pkg::VAR_FIRST:
      begin
        // Only one p pin carries the clock
        pin_oed[5:1] = 5'h00;
      end
      pcc_pkg::VAR_SECOND_TB:
      begin
        // Differential pair two is the feedback input
        if (pincfg_q[pcc_pkg::PIN_DIFF_LSB + 1])
          pin_oed[3:2] = 2'h0;
        // Differential pair three is an input
        if (pincfg_q[pcc_pkg::PIN_DIFF_LSB + 2])
          pin_oed[5:4] = 2'h0;
      end
      pcc_pkg::VAR_SECOND_LR:
      begin
        // Two pins; single-ended leaves pin one as feedback input
        pin_oed[5:2] = 4'h0;
        if (!pincfg_q[pcc_pkg::PIN_DIFF_LSB])
          pin_oed[1] = 1'b0;
      end
      default:
        pin_oed = 6'h00;
    endcase
    // Pins under user control leave the PLL path; never differential then
    for (int p = 0; p < 6; p++)
    begin
      if (pincfg_q[pcc_pkg::PIN_GPEN_LSB + p])
      begin
        pin_od[p] = pincfg_q[pcc_pkg::PIN_GPOUT_LSB + p];
        pin_oed[p] = 1'b1;
      end
    end
    // Clock pins are low while the PLL is in reset
    for (int p = 0; p < 6; p++)
    begin
      if (!pincfg_q[pcc_pkg::PIN_GPEN_LSB + p] && reset_req)
        pin_od[p] = 1'b0;
    end
  end

  // Pins leave straight from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_o <= 6'h00;
      pin_oe <= 6'h00;
    end
    else
    begin
      pin_o <= pin_od;
      pin_oe <= pin_oed;
    end
  end

  // ********************************************************
  // Status outputs and interrupts
  // ********************************************************

  // Lock and reset flags registered out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_locked <= 1'b0;
      pll_in_reset <= 1'b0;
    end
    else
    begin
      pll_locked <= (state_q == pcc_pkg::ST_LOCKED) && !reset_req;
      pll_in_reset <= reset_req;
    end
  end

  // Edge events on lock gained and lost; config error event whenever present and not yet flagged
  assign ev_lock = !pll_locked && state_q == pcc_pkg::ST_LOCKED && !reset_req;
  assign ev_loss = pll_locked && (state_q != pcc_pkg::ST_LOCKED || reset_req);
  assign events = {(!mode_ok || sel_err) && !irq_stat_q[pcc_pkg::EV_CFG], ev_loss, ev_lock};

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= 3'h0;
    else if (wr_en && paddr == pcc_pkg::IRQ_CLR_OFS)
      irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | events;
    else
      irq_stat_q <= irq_stat_q | events;
  end

  // Level interrupt from enabled status bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_en_q);
  end

  // ********************************************************
  // APB register port
  // ********************************************************

  // Software writes, taken at the edge where pready is sampled high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= pcc_pkg::CTRL_RESET;
      outsel_q <= pcc_pkg::SRC_MULT;
      pincfg_q <= 22'h000000;
      irq_en_q <= 3'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        pcc_pkg::CTRL_OFS: ctrl_q <= pwdata[11:0];
        pcc_pkg::OUTSEL_OFS: outsel_q <= pwdata[3:0];
        pcc_pkg::PINCFG_OFS: pincfg_q <= pwdata[21:0];
        pcc_pkg::IRQ_EN_OFS: irq_en_q <= pwdata[2:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Read mux and address decode
  always_comb
  begin
    rd_data = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      pcc_pkg::CTRL_OFS: rd_data = {20'h00000, ctrl_q};
      pcc_pkg::OUTSEL_OFS: rd_data = {28'h0000000, outsel_q};
      pcc_pkg::PINCFG_OFS: rd_data = {10'h000, pincfg_q};
      pcc_pkg::STATUS_OFS:
        rd_data = {10'h000, pin_s2_q, osc_ctrl_q, state_q,
                   sel_err, bw_eff, compensated, mode_ok, pll_in_reset, pll_locked};
      pcc_pkg::IRQ_STAT_OFS: rd_data = {29'h00000000, irq_stat_q};
      pcc_pkg::IRQ_EN_OFS: rd_data = {29'h00000000, irq_en_q};
      pcc_pkg::IRQ_CLR_OFS: rd_data = 32'h00000000;
      default: addr_ok = 1'b0;
    endcase
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_en)
        prdata <= rd_data;
    end
  end

endmodule
`default_nettype wire

// File: pcc_top_properties.sv
// Port-level concurrent checks for the PLL clock control block
`timescale 1ns/1ps
`default_nettype none
module pcc_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic areset_in,
  input wire logic pll_locked,
  input wire logic pll_in_reset,
  input wire logic irq
);
  // ********************************
  // Assertions, one clock domain
  // ********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One wait state, then a single-cycle answer
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after access phase");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_idle_a: assert property (!(psel && penable) |=> !pready)
    else $error("pready without a request");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // Sync plus flop gives about three cycles of lag
  reset_follow_a: assert property (areset_in [*5] |-> pll_in_reset)
    else $error("pll reset pin not followed");
  reset_unlock_a: assert property (pll_in_reset [*3] |-> !pll_locked)
    else $error("lock shown during pll reset");
  // Relock needs several reference edges after release
  lock_cause_a: assert property ($rose(pll_locked) |-> !pll_in_reset && !$past(pll_in_reset, 8))
    else $error("lock rose too soon after reset");
  // Main scenarios reached
  lock_seen_c: cover property ($rose(pll_locked));
  slverr_seen_c: cover property (pslverr);
  irq_seen_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: pcc_ctl_model.sv
// Model of the user logic that feeds reference, reset and gate pins
`timescale 1ns/1ps
`default_nettype none
module pcc_ctl_model (
  input wire logic pclk,
  input wire logic run,
  input wire logic rst_req,
  input wire logic gate_req,
  output logic ref_clk_in,
  output logic areset_in,
  output logic phase_detector_en_in
);
  logic [1:0] div_q; // Half-period count of the reference
  logic [4:0] stable_q; // Reference periods seen so far
  initial
  begin
    ref_clk_in = 1'b0;
    areset_in = 1'b1;
    phase_detector_en_in = 1'b1;
    div_q = 2'd0;
    stable_q = 5'd0;
  end
  // Dedicated reference at pclk/8; stands still when not running
  always @(posedge pclk)
  begin
    if (run)
    begin
      div_q <= div_q + 2'd1;
      if (div_q == 2'd3)
        ref_clk_in <= !ref_clk_in;
    end
  end
  // Reset held until the reference is stable, then on request
  always @(posedge pclk)
  begin
    if (run && ref_clk_in && div_q == 2'd3 && stable_q != 5'd31)
      stable_q <= stable_q + 5'd1;
    areset_in <= rst_req || stable_q < 5'd16;
    phase_detector_en_in <= gate_req;
  end
endmodule
`default_nettype wire

// File: pcc_top_tb.sv
// Self-checking testbench for the PLL clock control block
`timescale 1ns/1ps
`default_nettype none
module pcc_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic ref_clk_in, areset_in, phase_detector_en_in, pll_locked, pll_in_reset, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] pin_i, pin_o, pin_oe;
  logic run, rst_req, gate_req; // Partner commands
  int failures, comparisons, cycles;
  assign pin_i = pin_o; // Board loop for feedback pins
  pcc_top #(.LOCK_EDGES(4), .LOSS_CYC(16), .DRIFT_CYC(8)) i_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ref_clk_in,
    .areset_in, .phase_detector_en_in, .pin_i, .pin_o, .pin_oe, .pll_locked, .pll_in_reset,
    .irq);
  pcc_ctl_model i_ctl (.pclk, .run, .rst_req, .gate_req, .ref_clk_in, .areset_in,
    .phase_detector_en_in);
  // ********************************
  // Clock, timeout, helpers
  // ********************************
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard, far above the expected run
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      failures = failures + 1;
      conclude();
    end
  end
  task conclude;
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; waits for pready with no assumed latency
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task wait_lock;
    int n;
    n = 0;
    while (pll_locked !== 1'b1 && n < 600)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  function automatic logic [31:0] cw(input int v, input int m, input int n, input int h);
    return 32'(32'h802 | (v << 6) | (n << 8) | (h << 5) | (m << 2));
  endfunction
  // ********************************
  // Scenarios
  // ********************************
  task t_regs;
    rd_reg(pcc_pkg::CTRL_OFS);
    chk("ctrl", 32'h802, rd);
    rd_reg(pcc_pkg::OUTSEL_OFS);
    chk("outsel", 32'hf, rd);
    rd_reg(pcc_pkg::PINCFG_OFS);
    chk("pincfg", 32'h0, rd);
    wr_reg(pcc_pkg::IRQ_EN_OFS, 32'h7);
    rd_reg(pcc_pkg::IRQ_EN_OFS);
    chk("irq_en", 32'h7, rd);
    wr_reg(pcc_pkg::IRQ_EN_OFS, 32'h0);
    rd_reg(8'h1c);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", 32'h0, rd);
  endtask
  task t_lock_irq;
    wait_lock();
    chk("locked", 32'h1, 32'(pll_locked));
    rd_reg(pcc_pkg::STATUS_OFS);
    chk("stat_lock", 32'h1, 32'(rd[0]));
    rd_reg(pcc_pkg::IRQ_STAT_OFS);
    chk("irq_stat", 32'h1, 32'(rd[0]));
    chk("irq_masked", 32'h0, 32'(irq));
    wr_reg(pcc_pkg::IRQ_EN_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_on", 32'h1, 32'(irq));
    wr_reg(pcc_pkg::IRQ_CLR_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 32'h0, 32'(irq));
    wr_reg(pcc_pkg::IRQ_EN_OFS, 32'h0);
  endtask
  task t_areset;
    rst_req <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("in_reset", 32'h1, 32'(pll_in_reset));
    chk("unlocked", 32'h0, 32'(pll_locked));
    chk("pins_low", 32'h0, 32'(pin_o));
    rd_reg(pcc_pkg::STATUS_OFS);
    chk("osc_nominal", 32'h80, 32'(rd[15:8]));
    rd_reg(pcc_pkg::IRQ_STAT_OFS);
    chk("irq_loss", 32'h1, 32'(rd[1]));
    rst_req <= 1'b0;
    wait_lock();
    chk("relock", 32'h1, 32'(pll_locked));
    wr_reg(pcc_pkg::CTRL_OFS, 32'h803);
    repeat (4) @(posedge pclk);
    chk("sw_reset", 32'h1, 32'(pll_in_reset));
    wr_reg(pcc_pkg::CTRL_OFS, 32'h802);
    wait_lock();
    chk("sw_relock", 32'h1, 32'(pll_locked));
  endtask
  task t_gate;
    logic [7:0] w0;
    rd_reg(pcc_pkg::STATUS_OFS);
    w0 = rd[15:8];
    gate_req <= 1'b0;
    repeat (60) @(posedge pclk);
    rd_reg(pcc_pkg::STATUS_OFS);
    chk("osc_drift", 32'h1, 32'(rd[15:8] < w0));
    gate_req <= 1'b1;
  endtask
  // Validity and effective high bandwidth; ok above 1 skips that check
  task mode_chk(input int v, input int m, input int n, input int h, input int ok, input int bw);
    wr_reg(pcc_pkg::CTRL_OFS, cw(v, m, n, h));
    rd_reg(pcc_pkg::STATUS_OFS);
    if (ok < 2)
      chk("mode_ok", 32'(ok), 32'(rd[2]));
    chk("high_bw", 32'(bw), 32'(rd[4]));
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++)
      mode_chk(0, m, 0, 0, 1, 0);
    mode_chk(0, 4, 0, 0, 0, 0);
    mode_chk(0, 6, 0, 0, 0, 0);
    mode_chk(0, 5, 2, 0, 1, 0);
    mode_chk(0, 5, 6, 0, 1, 0);
    mode_chk(0, 5, 4, 0, 0, 0);
    mode_chk(1, 4, 0, 0, 1, 0);
    mode_chk(1, 5, 0, 0, 0, 0);
    mode_chk(1, 4, 0, 1, 2, 0);
    mode_chk(1, 2, 0, 1, 1, 1);
    mode_chk(2, 4, 0, 0, 1, 0);
    mode_chk(2, 2, 0, 0, 0, 0);
    wr_reg(pcc_pkg::CTRL_OFS, cw(0, 2, 0, 0));
    wait_lock();
    rd_reg(pcc_pkg::STATUS_OFS);
    chk("compensated", 32'h1, 32'(rd[3]));
    wr_reg(pcc_pkg::CTRL_OFS, cw(0, 2, 0, 0) & 32'hf7ff);
    rd_reg(pcc_pkg::STATUS_OFS);
    chk("uncompensated", 32'h0, 32'(rd[3]));
  endtask
  task src_chk(input int v, input int c, input int e);
    wr_reg(pcc_pkg::CTRL_OFS, cw(v, (v == 2) ? 4 : 2, 0, 0));
    wr_reg(pcc_pkg::OUTSEL_OFS, 32'(c));
    rd_reg(pcc_pkg::STATUS_OFS);
    chk("src_err", 32'(e), 32'(rd[5]));
  endtask
  task t_src;
    src_chk(0, 6, 0);
    src_chk(0, 7, 1);
    src_chk(0, 15, 0);
    src_chk(1, 9, 0);
    src_chk(1, 10, 1);
    src_chk(2, 6, 0);
    src_chk(2, 7, 1);
    rd_reg(pcc_pkg::IRQ_STAT_OFS);
    chk("irq_cfg", 32'h1, 32'(rd[2]));
  endtask
  task t_pins;
    wr_reg(pcc_pkg::CTRL_OFS, cw(1, 2, 0, 0));
    wr_reg(pcc_pkg::OUTSEL_OFS, 32'h0);
    wait_lock();
    repeat (3) @(posedge pclk);
    chk("pin_same", 32'h0, 32'(pin_o[0] ^ pin_o[1]));
    wr_reg(pcc_pkg::PINCFG_OFS, 32'h8);
    repeat (3) @(posedge pclk);
    chk("pin_inv", 32'h1, 32'(pin_o[0] ^ pin_o[1]));
    wr_reg(pcc_pkg::PINCFG_OFS, 32'h0010_1000);
    repeat (4) @(posedge pclk);
    chk("user_oe", 32'h1, 32'(pin_oe[4]));
    chk("user_hi", 32'h1, 32'(pin_o[4]));
    wr_reg(pcc_pkg::PINCFG_OFS, 32'h0000_1000);
    repeat (4) @(posedge pclk);
    chk("user_lo", 32'h0, 32'(pin_o[4]));
  endtask
  // Main sequence: reset first, then each scenario in turn
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b1;
    rst_req = 1'b0;
    gate_req = 1'b1;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_lock_irq();
    t_areset();
    t_gate();
    t_modes();
    t_src();
    t_pins();
    conclude();
  end
endmodule
bind pcc_top pcc_top_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .areset_in, .pll_locked, .pll_in_reset, .irq);
`default_nettype wire
